/* File: hdl/zero_adjust_and_diag_history.sv */
// Zero adjust command engine and overwrite mode diagnosis history
`timescale 1ns/100ps
module zero_adjust_and_diag_history #(
  parameter int FULL_SCALE        = 100000,
  parameter int ZA_TIMEOUT_CYCLES = zero_diag_pkg::ZA_TIMEOUT_DEF
)(
  input  wire logic                          clk_in,
  input  wire logic                          srst_in,
  input  wire logic                          obj_req_valid_in,
  input  wire zero_diag_pkg::obj_req_s       obj_req_in,
  output logic                               obj_ack_out,
  output logic                               obj_err_out,
  output logic [95:0]                        obj_rdata_out,
  input  wire logic signed [31:0]            pre_comp_in,
  input  wire logic signed [31:0]            output_offset_in,
  input  wire logic                          meas_valid_in,
  output logic signed [31:0]                 pressure_out,
  output logic signed [31:0]                 auto_zero_term_out,
  input  wire logic [zero_diag_pkg::EV_COUNT-2:0] fault_in,
  input  wire logic signed [31:0]            nv_azo_in,
  input  wire logic [7:0]                    nv_hist_avail_in,
  output logic                               nv_store_out,
  output logic signed [31:0]                 nv_azo_out
);
  localparam int NEV = zero_diag_pkg::EV_COUNT;
  localparam logic signed [31:0] AZ_LIMIT =
    32'(FULL_SCALE / 100 * zero_diag_pkg::FS_PERCENT);
  localparam logic [31:0] TIMEOUT_LAST = 32'(ZA_TIMEOUT_CYCLES - 1);

  // Refuse parameters the range check and timeout cannot serve
  if (FULL_SCALE < 100 || ZA_TIMEOUT_CYCLES < 2)
  begin
    $error("zero_adjust_and_diag_history: bad parameter value");
  end

  typedef enum logic [1:0] {ZA_IDLE, ZA_WAIT, ZA_CHECK} za_state_e;

  za_state_e                 za_state_ff;
  logic [31:0]               za_cnt_ff;
  logic signed [31:0]        target_ff;
  logic signed [31:0]        cand_ff;
  logic [47:0]               last_cmd_ff;
  logic [7:0]                za_status_ff;
  logic [7:0]                za_resp_ff;
  logic [7:0]                st_status_ff;
  logic signed [31:0]        azo_ff;
  logic                      boot_ff;
  logic                      nv_store_ff;
  logic signed [31:0]        nv_azo_ff;
  logic signed [31:0]        pressure_ff;
  logic [NEV-2:0]            fault_prev_ff;
  logic [NEV-1:0]            pending_ff;
  logic [4:0]                wr_ptr_ff;
  logic [7:0]                newest_ff;
  logic [7:0]                new_avail_ff;
  logic [15:0]               flags_ff;
  logic [31:0]               stamp_ff;
  logic                      ack_ff;
  logic                      err_ff;
  logic [95:0]               rdata_ff;
  zero_diag_pkg::diag_msg_s  hist_mem [zero_diag_pkg::HIST_DEPTH];

  logic signed [31:0]        ofs_int;
  logic                      sel_valid;
  logic [$clog2(NEV)-1:0]    sel_idx;
  logic [31:0]               sel_code;
  logic [3:0]                sel_type;
  logic [95:0]               rd_data;
  logic                      rd_ok;
  logic [NEV-1:0]            ev_rise;
  logic [NEV-1:0]            ev_clr;
  logic [7:0]                method;
  logic [4:0]                rd_slot;

  // Object decode shared by all writers
  function automatic logic hit(input zero_diag_pkg::obj_req_s r,
                               input logic [15:0] idx, input logic [7:0] si);
    hit = (r.index == idx) && (r.subidx == si);
  endfunction

  wire obj_wr    = obj_req_valid_in && obj_req_in.wr;
  wire za_wr     = obj_wr && hit(obj_req_in, zero_diag_pkg::OBJ_ZERO_ADJUST,
                                 zero_diag_pkg::SI_CMD);
  wire store_wr  = obj_wr && hit(obj_req_in, zero_diag_pkg::OBJ_STORE, zero_diag_pkg::SI_CMD)
                   && (obj_req_in.wdata[31:0] == zero_diag_pkg::STORE_SIG);
  wire flags_wr  = obj_wr && hit(obj_req_in, zero_diag_pkg::OBJ_HISTORY,
                                 zero_diag_pkg::SI_FLAGS);
  wire newest_rd = obj_req_valid_in && !obj_req_in.wr && (newest_ff != 8'h00) &&
                   hit(obj_req_in, zero_diag_pkg::OBJ_HISTORY, newest_ff);

  // Method sits in byte 0; bytes 2..5 hold the float offset
  assign method = obj_req_in.wdata[7:0];
  wire method_ok = (method == zero_diag_pkg::METHOD_NO_OFS) ||
                   (method == zero_diag_pkg::METHOD_ZERO_OFS) ||
                   (method == zero_diag_pkg::METHOD_OFS);
  wire za_start = za_wr && method_ok && (za_state_ff == ZA_IDLE);

  float_to_int u_ofs (
    .real_in (obj_req_in.wdata[47:16]),
    .int_out (ofs_int)
  );

  // Command sequencer; a new command while busy is dropped
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      za_state_ff <= ZA_IDLE;
    else
    begin
      case (za_state_ff)
        ZA_IDLE:  if (za_start) za_state_ff <= ZA_WAIT;
        ZA_WAIT:
        begin
          if (meas_valid_in)
            za_state_ff <= ZA_CHECK;
          else if (za_cnt_ff == TIMEOUT_LAST)
            za_state_ff <= ZA_IDLE;
        end
        ZA_CHECK: za_state_ff <= ZA_IDLE;
        default:  za_state_ff <= ZA_IDLE;
      endcase
    end
  end

  // Bound on the wait for a valid measurement
  always_ff @(posedge clk_in)
  begin
    if (srst_in || za_state_ff != ZA_WAIT)
      za_cnt_ff <= 32'h00000000;
    else
      za_cnt_ff <= za_cnt_ff + 32'h00000001;
  end

  // Target: zero for methods 0 and 1, the given offset for method 2
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      target_ff   <= 32'sh00000000;
      last_cmd_ff <= 48'h000000000000;
    end
    else if (za_start)
    begin
      last_cmd_ff <= obj_req_in.wdata;
      if (method == zero_diag_pkg::METHOD_OFS)
        target_ff <= ofs_int;
      else
        target_ff <= 32'sh00000000;
    end
  end

  // Candidate term, independent of the output offset
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      cand_ff <= 32'sh00000000;
    else if (za_state_ff == ZA_WAIT && meas_valid_in)
      cand_ff <= 32'(target_ff - pre_comp_in);
  end

  wire out_of_range = (cand_ff >= AZ_LIMIT) || (cand_ff <= -AZ_LIMIT);

  // Status and response; busy reads response zero
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      za_status_ff <= zero_diag_pkg::STAT_NONE;
      za_resp_ff   <= zero_diag_pkg::RESP_NONE;
    end
    else if (za_start)
    begin
      za_status_ff <= zero_diag_pkg::STAT_BUSY;
      za_resp_ff   <= zero_diag_pkg::RESP_OK;
    end
    else if (za_state_ff == ZA_CHECK)
    begin
      if (out_of_range)
      begin
        za_status_ff <= zero_diag_pkg::STAT_ERR;
        za_resp_ff   <= zero_diag_pkg::RESP_RANGE;
      end
      else
      begin
        za_status_ff <= zero_diag_pkg::STAT_OK;
        za_resp_ff   <= zero_diag_pkg::RESP_OK;
      end
    end
    else if (za_state_ff == ZA_WAIT && !meas_valid_in && za_cnt_ff == TIMEOUT_LAST)
    begin
      za_status_ff <= zero_diag_pkg::STAT_ERR;
      za_resp_ff   <= zero_diag_pkg::RESP_INVALID;
    end
  end

  // Boot pulse: one cycle after release the stored values are fetched
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      boot_ff <= 1'b1;
    else
      boot_ff <= 1'b0;
  end

  // Working term; a refused adjust leaves it alone
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      azo_ff <= 32'sh00000000;
    else if (boot_ff)
      azo_ff <= nv_azo_in;
    else if (za_state_ff == ZA_CHECK && !out_of_range)
      azo_ff <= cand_ff;
  end

  // Output offset stays applied on top of the term
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      pressure_ff <= 32'sh00000000;
    else
      pressure_ff <= 32'(pre_comp_in + azo_ff + output_offset_in);
  end

  // Store: copy the working term out with a one-cycle strobe
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      nv_store_ff  <= 1'b0;
      nv_azo_ff    <= 32'sh00000000;
      st_status_ff <= zero_diag_pkg::STAT_NONE;
    end
    else
    begin
      nv_store_ff <= store_wr;
      if (store_wr)
      begin
        nv_azo_ff    <= azo_ff;
        st_status_ff <= zero_diag_pkg::STAT_OK;
      end
    end
  end

  // Fault edges and the store event raise pending bits
  assign ev_rise = {store_wr, fault_in & ~fault_prev_ff};
  always_comb
  begin
    ev_clr = '0;
    if (sel_valid)
      ev_clr[sel_idx] = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      fault_prev_ff <= '0;
      pending_ff    <= '0;
    end
    else
    begin
      fault_prev_ff <= fault_in;
      pending_ff    <= (pending_ff & ~ev_clr) | ev_rise; // New edge beats the clear
    end
  end

  diag_event_select #(
    .N (NEV)
  ) u_sel (
    .pending_in (pending_ff),
    .valid_out  (sel_valid),
    .idx_out    (sel_idx),
    .code_out   (sel_code),
    .type_out   (sel_type)
  );

  // Timestamp skips zero so every message carries a live stamp
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      stamp_ff <= 32'h00000001;
    else if (stamp_ff == 32'hFFFFFFFF)
      stamp_ff <= 32'h00000001;
    else
      stamp_ff <= stamp_ff + 32'h00000001;
  end

  // Ring write; pointer wraps so the oldest slot is reused
  always_ff @(posedge clk_in)
  begin
    if (sel_valid)
    begin
      hist_mem[wr_ptr_ff].stamp   <= stamp_ff;
      hist_mem[wr_ptr_ff].text_id <= zero_diag_pkg::TEXT_ID_NONE;
      hist_mem[wr_ptr_ff].flags   <= {8'h00, 4'h0, sel_type};
      hist_mem[wr_ptr_ff].code    <= sel_code;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wr_ptr_ff <= 5'h00;
      newest_ff <= zero_diag_pkg::NEWEST_RESET;
    end
    else if (sel_valid)
    begin
      wr_ptr_ff <= wr_ptr_ff + 5'h01;
      newest_ff <= {3'h0, wr_ptr_ff} + zero_diag_pkg::SI_MSG_FIRST;
    end
  end

  // Availability: from stored data at boot, set by logging, read clears
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      new_avail_ff <= 8'h00;
    else if (boot_ff)
      new_avail_ff <= nv_hist_avail_in;
    else if (sel_valid)
      new_avail_ff <= 8'h01;
    else if (newest_rd)
      new_avail_ff <= 8'h00;
  end

  // Only the writable flag bits take new values
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      flags_ff <= zero_diag_pkg::FLAGS_RESET;
    else if (flags_wr)
      flags_ff <= (flags_ff & ~zero_diag_pkg::FLAGS_WR_MASK) |
                  (obj_req_in.wdata[15:0] & zero_diag_pkg::FLAGS_WR_MASK);
  end

  assign rd_slot = 5'(obj_req_in.subidx - zero_diag_pkg::SI_MSG_FIRST);

  // Read mux for every object this block owns
  always_comb
  begin
    rd_data = 96'h0;
    rd_ok   = 1'b1;
    case (obj_req_in.index)
      zero_diag_pkg::OBJ_ZERO_ADJUST:
        case (obj_req_in.subidx)
          zero_diag_pkg::SI_CMD:    rd_data = {48'h0, last_cmd_ff};
          zero_diag_pkg::SI_STATUS: rd_data = {88'h0, za_status_ff};
          zero_diag_pkg::SI_RESP:   rd_data = {88'h0, za_resp_ff};
          default:                  rd_ok   = 1'b0;
        endcase
      zero_diag_pkg::OBJ_STORE:
        case (obj_req_in.subidx)
          zero_diag_pkg::SI_STATUS: rd_data = {88'h0, st_status_ff};
          zero_diag_pkg::SI_RESP:   rd_data = {88'h0, st_status_ff};
          default:                  rd_ok   = 1'b0;
        endcase
      zero_diag_pkg::OBJ_HISTORY:
      begin
        if (obj_req_in.subidx >= zero_diag_pkg::SI_MSG_FIRST &&
            obj_req_in.subidx <= zero_diag_pkg::SI_MSG_LAST)
          rd_data = hist_mem[rd_slot];
        else
          case (obj_req_in.subidx)
            zero_diag_pkg::SI_CAPACITY:  rd_data = {88'h0, zero_diag_pkg::HIST_CAPACITY};
            zero_diag_pkg::SI_NEWEST:    rd_data = {88'h0, newest_ff};
            zero_diag_pkg::SI_ACKED:     rd_data = {88'h0, zero_diag_pkg::ACKED_VALUE};
            zero_diag_pkg::SI_NEW_AVAIL: rd_data = {88'h0, new_avail_ff};
            zero_diag_pkg::SI_FLAGS:     rd_data = {80'h0, flags_ff};
            default:                     rd_ok   = 1'b0;
          endcase
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Answer one cycle after the request; writes to the acked entry are absorbed
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 96'h0;
    end
    else
    begin
      ack_ff <= obj_req_valid_in;
      err_ff <= obj_req_valid_in && !rd_ok;
      if (obj_req_valid_in && !obj_req_in.wr)
        rdata_ff <= rd_data;
    end
  end

  assign obj_ack_out        = ack_ff;
  assign obj_err_out        = err_ff;
  assign obj_rdata_out      = rdata_ff;
  assign pressure_out       = pressure_ff;
  assign auto_zero_term_out = azo_ff;
  assign nv_store_out       = nv_store_ff;
  assign nv_azo_out         = nv_azo_ff;
endmodule

/* File: hdl/zero_diag_pkg.sv */
// Shared constants and types for zero adjust and diagnosis history
package zero_diag_pkg;
  // Object indices and subindices
  localparam logic [15:0] OBJ_ZERO_ADJUST = 16'hFB40;
  localparam logic [15:0] OBJ_STORE       = 16'hFBF2;
  localparam logic [15:0] OBJ_HISTORY     = 16'h10F3;
  localparam logic [7:0]  SI_CMD          = 8'h01;
  localparam logic [7:0]  SI_STATUS       = 8'h02;
  localparam logic [7:0]  SI_RESP         = 8'h03;
  localparam logic [7:0]  SI_CAPACITY     = 8'h01;
  localparam logic [7:0]  SI_NEWEST       = 8'h02;
  localparam logic [7:0]  SI_ACKED        = 8'h03;
  localparam logic [7:0]  SI_NEW_AVAIL    = 8'h04;
  localparam logic [7:0]  SI_FLAGS        = 8'h05;
  localparam logic [7:0]  SI_MSG_FIRST    = 8'h06;
  localparam logic [7:0]  SI_MSG_LAST     = 8'h25;
  // History layout and reset values
  localparam int          HIST_DEPTH      = 32;
  localparam logic [7:0]  HIST_CAPACITY   = 8'h20;
  localparam logic [7:0]  NEWEST_RESET    = 8'h00;
  localparam logic [7:0]  ACKED_VALUE     = 8'h00;
  localparam logic [15:0] FLAGS_RESET     = 16'h0000;
  localparam logic [15:0] FLAGS_WR_MASK   = 16'h000E;
  // Zero adjust method, status and response codes
  localparam logic [7:0]  METHOD_NO_OFS   = 8'h00;
  localparam logic [7:0]  METHOD_ZERO_OFS = 8'h01;
  localparam logic [7:0]  METHOD_OFS      = 8'h02;
  localparam logic [7:0]  STAT_NONE       = 8'h00;
  localparam logic [7:0]  STAT_OK         = 8'h01;
  localparam logic [7:0]  STAT_ERR        = 8'h03;
  localparam logic [7:0]  STAT_BUSY       = 8'hFF;
  localparam logic [7:0]  RESP_OK         = 8'h00;
  localparam logic [7:0]  RESP_RANGE      = 8'h02;
  localparam logic [7:0]  RESP_INVALID    = 8'h03;
  localparam logic [7:0]  RESP_NONE       = 8'hFE;
  localparam logic [31:0] STORE_SIG       = 32'h65766173;
  localparam int          FS_PERCENT      = 20;
  // Timing
  localparam int          ZA_TIME_MS      = 1000;
  localparam int          CLK_KHZ         = 20000;
  localparam int          ZA_TIMEOUT_DEF  = ZA_TIME_MS * CLK_KHZ;
  // Diagnosis codes and message fields
  localparam logic [15:0] VENDOR_LOW      = 16'hE000;
  localparam logic [15:0] MODULE_LOW      = 16'hE802;
  localparam logic [7:0]  MODULE_NO       = 8'h01;
  localparam logic [31:0] CODE_SUPPLY     = 32'h0010E000;
  localparam logic [31:0] CODE_HEATER_T   = 32'h0011E000;
  localparam logic [31:0] CODE_SENSOR_T   = 32'h0012E000;
  localparam logic [31:0] CODE_FLASH_CNT  = 32'h0003E000;
  localparam logic [31:0] CODE_PRESS_RNG  = 32'h0004E000;
  localparam logic [31:0] CODE_AUX_RNG    = 32'h0005E000;
  localparam logic [31:0] CODE_HEATER_C   = 32'h0006E000;
  localparam logic [3:0]  TYPE_INFO       = 4'h0;
  localparam logic [3:0]  TYPE_WARN       = 4'h1;
  localparam logic [3:0]  TYPE_ERROR      = 4'h2;
  localparam logic [15:0] TEXT_ID_NONE    = 16'h0000;
  localparam int          EV_COUNT        = 8;
  localparam int          EV_USER_PARAM   = 7;

  typedef struct packed {
    logic        wr;
    logic [15:0] index;
    logic [7:0]  subidx;
    logic [47:0] wdata;
  } obj_req_s;

  typedef struct packed {
    logic [31:0] stamp;
    logic [15:0] text_id;
    logic [15:0] flags;
    logic [31:0] code;
  } diag_msg_s;
endpackage

/* File: hdl/float_to_int.sv */
// Single precision float to signed integer, truncating and saturating
`timescale 1ns/100ps
module float_to_int (
  input  wire logic [31:0] real_in,
  output logic signed [31:0] int_out
);
  logic [7:0]  exp_raw;
  logic [54:0] mant;
  logic [54:0] mag;
  logic        sat;

  // Shift mantissa by unbiased exponent; tiny values truncate to zero
  always_comb
  begin
    exp_raw = real_in[30:23];
    mant    = {31'h0, 1'b1, real_in[22:0]};
    sat     = 1'b0;
    mag     = 55'h0;
    if (exp_raw < 8'h7F)
      mag = 55'h0;
    else if (exp_raw > 8'h9D)
      sat = 1'b1; // 2^31 and above cannot fit
    else if (exp_raw >= 8'h96)
      mag = mant << (exp_raw - 8'h96);
    else
      mag = mant >> (8'h96 - exp_raw);
  end

  // Apply sign
  always_comb
  begin
    if (sat)
      int_out = real_in[31] ? 32'sh80000001 : 32'sh7FFFFFFF;
    else if (real_in[31])
      int_out = -$signed(mag[31:0]);
    else
      int_out = $signed(mag[31:0]);
  end
endmodule

/* File: hdl/diag_event_select.sv */
// Picks the lowest pending diagnosis event and gives its code and type
`timescale 1ns/100ps
module diag_event_select #(
  parameter int N = zero_diag_pkg::EV_COUNT
)(
  input  wire logic [N-1:0]         pending_in,
  output logic                      valid_out,
  output logic [$clog2(N)-1:0]      idx_out,
  output logic [31:0]               code_out,
  output logic [3:0]                type_out
);
  // Refuse a table size the lookup does not cover
  if (N != zero_diag_pkg::EV_COUNT)
  begin
    $error("diag_event_select: N must match the event table");
  end

  // Reserved table entries are absent, so they can never be logged
  function automatic logic [35:0] lookup(input int i);
    case (i)
      0: lookup = {zero_diag_pkg::TYPE_ERROR, zero_diag_pkg::CODE_SUPPLY};
      1: lookup = {zero_diag_pkg::TYPE_ERROR, zero_diag_pkg::CODE_HEATER_T};
      2: lookup = {zero_diag_pkg::TYPE_ERROR, zero_diag_pkg::CODE_SENSOR_T};
      3: lookup = {zero_diag_pkg::TYPE_WARN,  zero_diag_pkg::CODE_FLASH_CNT};
      4: lookup = {zero_diag_pkg::TYPE_WARN,  zero_diag_pkg::CODE_PRESS_RNG};
      5: lookup = {zero_diag_pkg::TYPE_WARN,  zero_diag_pkg::CODE_AUX_RNG};
      6: lookup = {zero_diag_pkg::TYPE_ERROR, zero_diag_pkg::CODE_HEATER_C};
      // Module message: number in 16..23, zero above
      default: lookup = {zero_diag_pkg::TYPE_INFO, 8'h00, zero_diag_pkg::MODULE_NO,
                         zero_diag_pkg::MODULE_LOW};
    endcase
  endfunction

  // Lowest index wins; vendor codes all sit in the E000 low range
  always_comb
  begin
    valid_out = 1'b0;
    idx_out   = '0;
    code_out  = {16'h0000, zero_diag_pkg::VENDOR_LOW};
    type_out  = zero_diag_pkg::TYPE_INFO;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (pending_in[i])
      begin
        valid_out            = 1'b1;
        idx_out              = ($clog2(N))'(i);
        {type_out, code_out} = lookup(i);
      end
    end
  end
endmodule

/* File: tb/zad_monitor.sv */
// Checker for object answers, term bounds and the store pulse
`timescale 1ns/100ps
module zad_monitor #(
  parameter int FULL_SCALE = 100000
)(
  input wire logic                    clk_in,
  input wire logic                    srst_in,
  input wire logic                    obj_req_valid_in,
  input wire zero_diag_pkg::obj_req_s obj_req_in,
  input wire logic                    obj_ack_out,
  input wire logic [95:0]             obj_rdata_out,
  input wire logic signed [31:0]      pre_comp_in,
  input wire logic signed [31:0]      output_offset_in,
  input wire logic signed [31:0]      pressure_out,
  input wire logic signed [31:0]      auto_zero_term_out,
  input wire logic                    nv_store_out,
  input wire logic signed [31:0]      nv_azo_out
);
  localparam int LIM = FULL_SCALE / 100 * 20;
  // Decoded requests; a store only counts with its signature
  wire logic rd_h = obj_req_valid_in && !obj_req_in.wr && obj_req_in.index == 16'h10F3;
  wire logic rd_m = rd_h && obj_req_in.subidx > 8'h05 && obj_req_in.subidx < 8'h26;
  wire logic st   = obj_req_valid_in && obj_req_in.wr && obj_req_in.index == 16'hFBF2
                    && obj_req_in.subidx == 8'h01 && obj_req_in.wdata[31:0] == 32'h65766173;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence s_msg;
    rd_m ##1 obj_ack_out;
  endsequence
  property p_press;
    !$past(srst_in) |-> pressure_out == $past(pre_comp_in) + $past(auto_zero_term_out)
      + $past(output_offset_in);
  endproperty
  a_press: assert property (p_press) else $error("pressure sum wrong");
  property p_store;
    st |=> nv_store_out && nv_azo_out == $past(auto_zero_term_out);
  endproperty
  a_store: assert property (p_store) else $error("store copy wrong");
  property p_store_src;
    nv_store_out |-> $past(st);
  endproperty
  a_store_src: assert property (p_store_src) else $error("stray store");
  property p_bound;
    $changed(auto_zero_term_out) && !$past(srst_in, 2) |->
      auto_zero_term_out < LIM && auto_zero_term_out > -LIM;
  endproperty
  a_bound: assert property (p_bound) else $error("term out of range");
  property p_acked;
    rd_h && obj_req_in.subidx == 8'h03 |=> obj_ack_out && obj_rdata_out == '0;
  endproperty
  a_acked: assert property (p_acked) else $error("acked entry not zero");
  property p_flags;
    rd_h && obj_req_in.subidx == 8'h05 |=> (obj_rdata_out & ~96'hE) == '0;
  endproperty
  a_flags: assert property (p_flags) else $error("flag bit out of mask");
  property p_fields;
    s_msg |-> obj_rdata_out[63:36] == '0;
  endproperty
  a_fields: assert property (p_fields) else $error("message field not zero");
  property p_code;
    s_msg |-> obj_rdata_out[15:0] == 16'hE000 || obj_rdata_out[31:0] == 32'h0001E802;
  endproperty
  a_code: assert property (p_code) else $error("code outside used ranges");
endmodule
bind zero_adjust_and_diag_history zad_monitor #(.FULL_SCALE(FULL_SCALE)) u_zad_monitor (
  .clk_in, .srst_in, .obj_req_valid_in, .obj_req_in, .obj_ack_out, .obj_rdata_out,
  .pre_comp_in, .output_offset_in, .pressure_out, .auto_zero_term_out, .nv_store_out,
  .nv_azo_out);

/* File: tb/obj_master.sv */
// Fieldbus master model issuing object accesses
`timescale 1ns/100ps
module obj_master (
  input  wire logic               clk_in,
  input  wire logic               ack_in,
  input  wire logic               err_in,
  input  wire logic [95:0]        rdata_in,
  output logic                    valid_out,
  output zero_diag_pkg::obj_req_s req_out
);
  initial {valid_out, req_out} = '0;
  // One-cycle request; released fields flip so stale values never look valid
  task automatic access(input logic w, input logic [15:0] ix, input logic [7:0] si,
                        input logic [47:0] wd, output logic [97:0] r);
    @(posedge clk_in);
    valid_out <= 1'b1;
    req_out <= '{w, ix, si, wd};
    @(posedge clk_in);
    valid_out <= 1'b0;
    req_out <= ~req_out;
    @(posedge clk_in);
    r = {ack_in, err_in, rdata_in};
  endtask
endmodule

/* File: tb/zero_adjust_and_diag_history_test.sv */
// Self-checking bench for zero adjust and diagnosis history
`timescale 1ns/100ps
module zero_adjust_and_diag_history_test;
  localparam logic [15:0] H = 16'h10F3;
  localparam logic [15:0] Z = 16'hFB40;
  localparam logic [95:0] M = 96'hFFFF_FFFF_FFFF_FFFF;
  logic                    clk_in, srst_in, meas_valid_in, obj_req_valid_in;
  logic                    obj_ack_out, obj_err_out, nv_store_out;
  zero_diag_pkg::obj_req_s obj_req_in;
  logic [95:0]             obj_rdata_out, d;
  logic [97:0]             r;
  logic signed [31:0]      pre_comp_in, output_offset_in, pressure_out;
  logic signed [31:0]      auto_zero_term_out, nv_azo_in, nv_azo_out;
  logic [6:0]              fault_in;
  logic [7:0]              nv_hist_avail_in;
  logic [35:0]             tbl [7];
  int                      errors, tests_run;
  zero_adjust_and_diag_history #(.ZA_TIMEOUT_CYCLES(50)) u_zero_adjust_and_diag_history (
    .clk_in, .srst_in, .obj_req_valid_in, .obj_req_in, .obj_ack_out, .obj_err_out,
    .obj_rdata_out, .pre_comp_in, .output_offset_in, .meas_valid_in, .pressure_out,
    .auto_zero_term_out, .fault_in, .nv_azo_in, .nv_hist_avail_in, .nv_store_out,
    .nv_azo_out);
  obj_master u_obj_master (.clk_in, .ack_in(obj_ack_out), .err_in(obj_err_out),
    .rdata_in(obj_rdata_out), .valid_out(obj_req_valid_in), .req_out(obj_req_in));
  // Clock and a watchdog well past the expected run
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    complete_run();
  end
  task automatic chk(input logic [97:0] g, input logic [97:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Reads expect an ack without error; the mask hides the timestamp
  task automatic rd(input logic [15:0] ix, input logic [7:0] si, input logic [95:0] e,
                    input logic [95:0] m = '1);
    u_obj_master.access(1'b0, ix, si, '0, r);
    d = r[95:0];
    chk({r[97:96], d & m}, {2'b10, e});
  endtask
  task automatic rst();
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  // Measurement held invalid until busy is seen, then released or left to time out
  task automatic za(input logic [7:0] m, input logic [31:0] f, input logic [7:0] st,
                    input logic [7:0] rs, input logic signed [31:0] t, input logic v,
                    input logic signed [31:0] p);
    meas_valid_in <= 1'b0;
    u_obj_master.access(1'b1, Z, 8'h01, {f, 8'h01, m}, r);
    rd(Z, 8'h02, 96'hFF);
    meas_valid_in <= v;
    repeat (v ? 4 : 60) @(posedge clk_in);
    rd(Z, 8'h02, st);
    rd(Z, 8'h03, rs);
    chk(auto_zero_term_out, t);
    chk(pressure_out, p);
    $display("zero adjust method %0d done", m);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Header entries after the first power-up, and an entry past the last message
  task automatic hdr();
    chk(auto_zero_term_out, -2);
    rd(H, 8'h01, 96'h20);
    rd(H, 8'h04, 96'h1);
    u_obj_master.access(1'b1, H, 8'h03, 48'h5, r);
    rd(H, 8'h03, 96'h0);
    rd(H, 8'h05, 96'h0);
    u_obj_master.access(1'b1, H, 8'h05, 48'hFFFF, r);
    rd(H, 8'h05, 96'hE);
    u_obj_master.access(1'b0, H, 8'h26, '0, r);
    chk(r[97:96], 2'b11);
    $display("history header done");
  endtask
  // Nonvolatile model keeps what the store handed out; power-up brings it back
  task automatic store();
    u_obj_master.access(1'b1, 16'hFBF2, 8'h01, 48'h65766173, r);
    chk(nv_azo_out, -16);
    nv_azo_in <= nv_azo_out;
    rst();
    chk(auto_zero_term_out, -16);
    $display("store and power-up done");
  endtask
  // All faults at once, then one code repeated past the capacity
  task automatic hist();
    fault_in <= 7'h7F;
    repeat (12) @(posedge clk_in);
    for (int i = 0; i < 7; i++)
    begin
      rd(H, 8'h06 + 8'(i), {60'h0, tbl[i]}, M);
      chk(d[95:64] != 0, 1'b1);
    end
    repeat (53)
    begin
      @(posedge clk_in);
      fault_in <= {~fault_in[6], 6'h0};
    end
    repeat (4) @(posedge clk_in);
    rd(H, 8'h02, 96'h6);
    rd(H, 8'h06, {60'h0, tbl[6]}, M);
    $display("history wrap done");
  endtask
  initial
  begin
    {srst_in, meas_valid_in, fault_in, errors, tests_run} = '0;
    srst_in = 1'b1;
    {pre_comp_in, output_offset_in} = {32'sd23, 32'sd5};
    {nv_azo_in, nv_hist_avail_in}   = {-32'sd2, 8'h01};
    tbl = '{36'h20010E000, 36'h20011E000, 36'h20012E000, 36'h10003E000,
            36'h10004E000, 36'h10005E000, 36'h20006E000};
    rst();
    hdr();
    za(8'h00, 32'h0, 8'h01, 8'h00, -23, 1'b1, 5);
    za(8'h01, 32'h0, 8'h01, 8'h00, -23, 1'b1, 5);
    za(8'h02, 32'h40E00000, 8'h01, 8'h00, -16, 1'b1, 12);
    pre_comp_in <= 20000;
    za(8'h00, 32'h0, 8'h03, 8'h02, -16, 1'b1, 19989);
    za(8'h00, 32'h0, 8'h03, 8'h03, -16, 1'b0, 19989);
    store();
    hist();
    complete_run();
  end
endmodule
